// file: verilog/tmn_pkg.sv
package tmn_pkg;
  // read addresses
  localparam logic [7:0] A_LOCAL_VAL  = 8'h00;
  localparam logic [7:0] A_REMOTE_HI  = 8'h01;
  localparam logic [7:0] A_STATUS     = 8'h02;
  localparam logic [7:0] A_CFG_RD     = 8'h03;
  localparam logic [7:0] A_RATE_RD    = 8'h04;
  localparam logic [7:0] A_LHI_RD     = 8'h05;
  localparam logic [7:0] A_LLO_RD     = 8'h06;
  localparam logic [7:0] A_RHI_RD     = 8'h07;
  localparam logic [7:0] A_RLO_RD     = 8'h08;
  localparam logic [7:0] A_REMOTE_LO  = 8'h10;
  localparam logic [7:0] A_MFR_ID     = 8'hFE;
  // write addresses
  localparam logic [7:0] A_CFG_WR     = 8'h09;
  localparam logic [7:0] A_RATE_WR    = 8'h0A;
  localparam logic [7:0] A_LHI_WR     = 8'h0B;
  localparam logic [7:0] A_LLO_WR     = 8'h0C;
  localparam logic [7:0] A_RHI_WR     = 8'h0D;
  localparam logic [7:0] A_RLO_WR     = 8'h0E;
  localparam logic [7:0] A_ONESHOT    = 8'h0F;
  // shared read/write addresses
  localparam logic [7:0] A_OFS_HI     = 8'h11;
  localparam logic [7:0] A_OFS_LO     = 8'h12;
  localparam logic [7:0] A_RHI_LO     = 8'h13;
  localparam logic [7:0] A_RLO_LO     = 8'h14;
  localparam logic [7:0] A_RTHERM     = 8'h19;
  localparam logic [7:0] A_LTHERM     = 8'h20;
  localparam logic [7:0] A_HYST       = 8'h21;
  // storage slots of the writable registers
  localparam int         NUM_SLOTS    = 13;
  localparam logic [3:0] SL_CFG       = 4'h0;
  localparam logic [3:0] SL_RATE      = 4'h1;
  localparam logic [3:0] SL_LHI       = 4'h2;
  localparam logic [3:0] SL_LLO       = 4'h3;
  localparam logic [3:0] SL_RHI       = 4'h4;
  localparam logic [3:0] SL_RLO       = 4'h5;
  localparam logic [3:0] SL_OFS_HI    = 4'h6;
  localparam logic [3:0] SL_OFS_LO    = 4'h7;
  localparam logic [3:0] SL_RHI_LO    = 4'h8;
  localparam logic [3:0] SL_RLO_LO    = 4'h9;
  localparam logic [3:0] SL_RTHERM    = 4'hA;
  localparam logic [3:0] SL_LTHERM    = 4'hB;
  localparam logic [3:0] SL_HYST      = 4'hC;
  localparam logic [7:0] RATE_RST     = 8'h08;
  localparam logic [7:0] REG_RST [NUM_SLOTS] = '{8'h00, RATE_RST, 8'h55, 8'h00, 8'h55, 8'h00,
                                                 8'h00, 8'h00, 8'h00, 8'h00, 8'h55, 8'h55, 8'h0A};
  // configuration bits
  localparam int         CFG_MASK     = 7;
  localparam int         CFG_STBY     = 6;
  localparam int         CFG_MFP      = 5;
  localparam int         CFG_EXT      = 2;
  // conversion rate
  localparam logic [3:0] RATE_MAX     = 4'hA;
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned FASTEST_NS     = 15_500_000;
  localparam int unsigned FASTEST_CYC    = FASTEST_NS / CLK_PERIOD_NS;
  // result formatting, quarter degrees
  localparam logic signed [11:0] EXT_BIAS_Q = 12'sh100;
  localparam logic signed [11:0] STD_MAX_Q  = 12'sh1FC;
  localparam logic signed [11:0] EXT_MAX_Q  = 12'sh3FF;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_UPD  = 3'b100
  } tmn_state_t;
endpackage : tmn_pkg

// file: verilog/tmn_rate_timer.sv
`timescale 1ns/1ns
module tmn_rate_timer
  import tmn_pkg::*;
#(
  parameter int unsigned FASTEST_CYC_P = FASTEST_CYC
)(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic [3:0] rate_code,
  input  wire logic       standby,
  input  wire logic       one_shot,
  input  wire logic       idle,
  output logic            start
);
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic        pend;
  logic        next_pend;
  logic [3:0]  shift;
  logic [31:0] limit;
  logic        tick;

  always_comb
  begin
    shift     = (rate_code > RATE_MAX) ? 4'h0 : RATE_MAX - rate_code;
    limit     = 32'(FASTEST_CYC_P) << shift;
    tick      = !standby && (cnt == 32'h0);
    next_cnt  = (standby || cnt >= limit - 32'h1) ? 32'h0 : cnt + 32'h1;
    start     = pend && idle;
    next_pend = (pend && !start) || tick || (one_shot && standby);
  end

  // counter and pending start
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt  <= 32'h0;
      pend <= 1'b0;
    end
    else
    begin
      cnt  <= next_cnt;
      pend <= next_pend;
    end
  end
endmodule : tmn_rate_timer

// file: verilog/tmn_result_format.sv
`timescale 1ns/1ns
module tmn_result_format
  import tmn_pkg::*;
(
  input  wire logic       ext,
  input  wire logic [7:0] local_meas,
  input  wire logic [9:0] remote_meas,
  input  wire logic [9:0] offset,
  output logic      [7:0] local_code,
  output logic      [9:0] remote_code
);
  // clamps a biased quarter-degree value to the selected range
  function automatic logic [9:0] fmt(input logic signed [11:0] q, input logic e);
    logic signed [11:0] b;
    logic signed [11:0] top;
    b   = q + (e ? EXT_BIAS_Q : 12'sh000);
    top = e ? EXT_MAX_Q : STD_MAX_Q;
    if (b < 12'sh000)
      fmt = 10'h000;
    else if (b > top)
      fmt = top[9:0];
    else
      fmt = b[9:0];
  endfunction : fmt

  logic signed [11:0] lq;
  logic signed [11:0] rq;
  logic        [9:0]  lf;

  always_comb
  begin
    lq          = {{2{local_meas[7]}}, local_meas, 2'b00};
    rq          = {{2{remote_meas[9]}}, remote_meas} + {{2{offset[9]}}, offset};
    lf          = fmt(lq, ext);
    local_code  = lf[9:2];
    remote_code = fmt(rq, ext);
  end
endmodule : tmn_result_format

// file: verilog/tmn_monitor.sv
`timescale 1ns/1ns
// What this block does
// - conversion interval from low rate nibble, powers of two, 16 s to 15.5 ms
// - every conversion period converts both local and remote channels
// - rate register resets to code 0x08, sixteen per second
// - high flag when value above limit, low flag when at or below
// - overtemp pin low while local or remote overtemp limit exceeded
// - second overtemp mode drives pin from high limits only
// - overtemp outputs release at limit minus shared hysteresis
// - limits kept and compared as raw codes after format change
// - status bit 7 shows conversion in progress
// - status bits 6 to 2 show limit violations and open sensor
// - status bits 1 and 0 show remote and local overtemp
// - alert mode: any of bits 6 to 2 sets alert latch
// - status read clears only flags whose condition has gone
// - alert latch cleared by alert response read only when clean
// - bits 1 and 0 do not latch, clear by themselves
// - second overtemp mode latches only bit 2
// - signed ten bit offset added to remote result
// - offset spans minus 128 to plus 127.75 in quarters
// - offset resets to zero, no effect until written
// - one-shot write in standby runs one conversion
// - configuration bit 6 selects standby, port and outputs alive
// - configuration bit 5 selects pin function
// - configuration bit 7 masks alert in alert mode only
// - extended range adds 64, default clamps 0 to 127
module tmn_monitor
  import tmn_pkg::*;
#(
  parameter int unsigned FASTEST_CYC_P = FASTEST_CYC,
  parameter logic [7:0]  MFR_ID_P      = 8'h5A  // arbitrary value
)(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       alert_resp_rd,
  output logic            alert_pending,
  output logic            conv_start,
  input  wire logic       conv_done,
  input  wire logic [7:0] local_meas,
  input  wire logic [9:0] remote_meas,
  input  wire logic       remote_open,
  output logic            overtemp_out_n,
  output logic            overtemp_oe,
  output logic            mfp_out_n,
  output logic            mfp_oe
);
  // maps a write address to its storage slot
  function automatic logic [4:0] wr_slot(input logic [7:0] a);
    case (a)
      A_CFG_WR:  wr_slot = {1'b1, SL_CFG};
      A_RATE_WR: wr_slot = {1'b1, SL_RATE};
      A_LHI_WR:  wr_slot = {1'b1, SL_LHI};
      A_LLO_WR:  wr_slot = {1'b1, SL_LLO};
      A_RHI_WR:  wr_slot = {1'b1, SL_RHI};
      A_RLO_WR:  wr_slot = {1'b1, SL_RLO};
      A_OFS_HI:  wr_slot = {1'b1, SL_OFS_HI};
      A_OFS_LO:  wr_slot = {1'b1, SL_OFS_LO};
      A_RHI_LO:  wr_slot = {1'b1, SL_RHI_LO};
      A_RLO_LO:  wr_slot = {1'b1, SL_RLO_LO};
      A_RTHERM:  wr_slot = {1'b1, SL_RTHERM};
      A_LTHERM:  wr_slot = {1'b1, SL_LTHERM};
      A_HYST:    wr_slot = {1'b1, SL_HYST};
      default:   wr_slot = 5'h00;
    endcase
  endfunction : wr_slot

  // maps a read address to its storage slot
  function automatic logic [4:0] rd_slot(input logic [7:0] a);
    case (a)
      A_CFG_RD:  rd_slot = {1'b1, SL_CFG};
      A_RATE_RD: rd_slot = {1'b1, SL_RATE};
      A_LHI_RD:  rd_slot = {1'b1, SL_LHI};
      A_LLO_RD:  rd_slot = {1'b1, SL_LLO};
      A_RHI_RD:  rd_slot = {1'b1, SL_RHI};
      A_RLO_RD:  rd_slot = {1'b1, SL_RLO};
      default:   rd_slot = wr_slot(a);
    endcase
  endfunction : rd_slot

  // set above the limit, cleared once at or below limit minus hysteresis
  function automatic logic hyst_state(input logic s, input logic [7:0] v, input logic [7:0] lim,
                                      input logic [7:0] h);
    hyst_state = (v > lim) || (s && ({1'b0, v} + {1'b0, h} > {1'b0, lim}));
  endfunction : hyst_state

  logic [7:0]  regs      [NUM_SLOTS];
  logic [7:0]  next_regs [NUM_SLOTS];
  tmn_state_t  state;
  tmn_state_t  next_state;
  logic [7:0]  local_val;
  logic [7:0]  next_local_val;
  logic [9:0]  remote_val;
  logic [9:0]  next_remote_val;
  logic        open_st;
  logic        next_open_st;
  logic [6:2]  flags;
  logic [6:2]  next_flags;
  logic [3:0]  ts;
  logic [3:0]  next_ts;
  logic        alert_latch;
  logic        next_alert_latch;
  logic        next_overtemp_oe;
  logic        next_mfp_oe;
  logic [7:0]  next_reg_rdata;
  logic [7:0]  cfg;
  logic        stby;
  logic        mfp2;
  logic        one_shot;
  logic        start;
  logic        upd;
  logic        busy;
  logic        st_rd;
  logic [6:2]  cond;
  logic [6:2]  clr;
  logic [6:2]  latch_m;
  logic [7:0]  status;
  logic [4:0]  ws;
  logic [4:0]  rs;
  logic [7:0]  fmt_local;
  logic [9:0]  fmt_remote;

  assign cfg      = regs[SL_CFG];
  assign stby     = cfg[CFG_STBY];
  assign mfp2     = cfg[CFG_MFP];
  assign one_shot = reg_wr && (reg_addr == A_ONESHOT);
  assign upd      = (state == ST_UPD);
  assign busy     = (state != ST_IDLE);
  assign st_rd    = reg_rd && (reg_addr == A_STATUS);

  // conversion pacing and one-shot requests
  tmn_rate_timer #(
    .FASTEST_CYC_P (FASTEST_CYC_P)
  ) u_timer (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .rate_code (regs[SL_RATE][3:0]),
    .standby   (stby),
    .one_shot  (one_shot),
    .idle      (state == ST_IDLE),
    .start     (start)
  );
  assign conv_start = start;

  tmn_result_format u_fmt (
    .ext         (cfg[CFG_EXT]),
    .local_meas  (local_meas),
    .remote_meas (remote_meas),
    .offset      ({regs[SL_OFS_HI], regs[SL_OFS_LO][7:6]}),
    .local_code  (fmt_local),
    .remote_code (fmt_remote)
  );

  // register writes and the conversion sequence
  always_comb
  begin
    ws              = wr_slot(reg_addr);
    next_regs       = regs;
    next_state      = state;
    next_local_val  = local_val;
    next_remote_val = remote_val;
    next_open_st    = open_st;
    if (reg_wr && ws[4])
      next_regs[ws[3:0]] = reg_wdata;
    case (state)
      ST_IDLE:
        if (start)
          next_state = ST_CONV;
      ST_CONV:
        if (conv_done)
        begin
          next_local_val  = fmt_local;
          next_remote_val = fmt_remote;
          next_open_st    = remote_open;
          next_state      = ST_UPD;
        end
      ST_UPD:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      regs       <= REG_RST;
      state      <= ST_IDLE;
      local_val  <= 8'h00;
      remote_val <= 10'h000;
      open_st    <= 1'b0;
    end
    else
    begin
      regs       <= next_regs;
      state      <= next_state;
      local_val  <= next_local_val;
      remote_val <= next_remote_val;
      open_st    <= next_open_st;
    end
  end

  // flags, hysteresis states, alert latch and pin enables
  always_comb
  begin
    cond[6] = local_val > regs[SL_LHI];
    cond[5] = local_val <= regs[SL_LLO];
    cond[4] = remote_val > {regs[SL_RHI], regs[SL_RHI_LO][7:6]};
    cond[3] = remote_val <= {regs[SL_RLO], regs[SL_RLO_LO][7:6]};
    cond[2] = open_st;
    latch_m = mfp2 ? 5'h01 : 5'h1F;
    clr     = st_rd ? ~cond : 5'h00;
    next_flags = upd ? ((flags & ~clr & latch_m) | cond) : (flags & ~clr);
    next_ts[0] = hyst_state(ts[0], local_val, regs[SL_LTHERM], regs[SL_HYST]);
    next_ts[1] = hyst_state(ts[1], remote_val[9:2], regs[SL_RTHERM], regs[SL_HYST]);
    next_ts[2] = hyst_state(ts[2], local_val, regs[SL_LHI], regs[SL_HYST]);
    next_ts[3] = hyst_state(ts[3], remote_val[9:2], regs[SL_RHI], regs[SL_HYST]);
    next_alert_latch = (!mfp2 && |flags) ||
                       (alert_latch && !(alert_resp_rd && flags == 5'h00 && cond == 5'h00));
    next_overtemp_oe = ts[0] || ts[1];
    next_mfp_oe = mfp2 ? (ts[2] || ts[3]) : (alert_latch && !cfg[CFG_MASK]);
  end

  // registered flag and pin state
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      flags       <= 5'h00;
      ts          <= 4'h0;
      alert_latch <= 1'b0;
      overtemp_oe <= 1'b0;
      mfp_oe      <= 1'b0;
    end
    else
    begin
      flags       <= next_flags;
      ts          <= next_ts;
      alert_latch <= next_alert_latch;
      overtemp_oe <= next_overtemp_oe;
      mfp_oe      <= next_mfp_oe;
    end
  end

  assign overtemp_out_n = 1'b0;  // open drain, only the enable moves
  assign mfp_out_n      = 1'b0;
  assign alert_pending  = alert_latch;

  // read data mux
  always_comb
  begin
    status         = {busy, flags, ts[1], ts[0]};
    rs             = rd_slot(reg_addr);
    next_reg_rdata = reg_rdata;
    if (reg_rd)
    begin
      case (reg_addr)
        A_LOCAL_VAL: next_reg_rdata = local_val;
        A_REMOTE_HI: next_reg_rdata = remote_val[9:2];
        A_REMOTE_LO: next_reg_rdata = {remote_val[1:0], 6'h00};
        A_STATUS:    next_reg_rdata = status;
        A_MFR_ID:    next_reg_rdata = MFR_ID_P;
        default:     next_reg_rdata = rs[4] ? regs[rs[3:0]] : 8'h00;
      endcase
    end
  end

  // read data register
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= next_reg_rdata;
  end

  rate_reset_a: assert property (@(posedge core_clk) $rose(nrst) |-> regs[SL_RATE] == RATE_RST)
    else $error("rate register not at reset code");
  busy_bit_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (state == ST_CONV && conv_done) |=> status[7] ##1 (state == ST_IDLE && !status[7]))
    else $error("busy bit wrong around result store");
  high_flag_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (upd && local_val > regs[SL_LHI]) |=> flags[6])
    else $error("local high flag not set above limit");
  low_flag_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (upd && local_val <= regs[SL_LLO]) |=> flags[5])
    else $error("local low flag not set at limit");
  overtemp_pin_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (local_val > regs[SL_LTHERM]) [*3] |-> overtemp_oe)
    else $error("overtemp pin not driven");
  alert_pin_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (!mfp2 && flags != 5'h00 && !cfg[CFG_MASK]) [*3] |-> mfp_oe)
    else $error("alert pin not driven");
  status_keep_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (st_rd && flags[6] && cond[6]) |=> flags[6])
    else $error("status read cleared a live fault");
  latch_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (alert_latch && !alert_resp_rd) |=> alert_latch)
    else $error("alert latch cleared without alert response");
  one_shot_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (one_shot && stby && state == ST_IDLE) |-> ##2 (state == ST_CONV))
    else $error("one-shot did not start a conversion");
endmodule : tmn_monitor

// file: test/tmn_host_model.sv
`timescale 1ns/1ns
module tmn_host_model
  import tmn_pkg::*;
(
  input  wire logic       core_clk,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic            alert_resp_rd
);
  // bus idle at time zero
  initial
  begin
    reg_addr      = 8'h00;
    reg_wdata     = 8'h00;
    reg_wr        = 1'b0;
    reg_rd        = 1'b0;
    alert_resp_rd = 1'b0;
  end

  // one write, strobe held for one cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr  <= a;
    reg_wdata <= (a == A_RATE_WR) ? (d & 8'h0F) : d;
    reg_wr    <= 1'b1;
    @(negedge core_clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;  // stale data is not left on the bus
    reg_addr  <= ~a;
  endtask : wr

  // one read, data sampled by the bench a cycle later
  task automatic rd(input logic [7:0] a);
    @(negedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(negedge core_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
  endtask : rd

  task automatic ack();
    @(negedge core_clk);
    alert_resp_rd <= 1'b1;
    @(negedge core_clk);
    alert_resp_rd <= 1'b0;
  endtask : ack
endmodule : tmn_host_model

// file: test/tmn_monitor_tb_top.sv
`timescale 1ns/1ns
module tmn_monitor_tb_top
  import tmn_pkg::*;
;
  logic        core_clk;
  logic        nrst;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        alert_resp_rd;
  logic        alert_pending;
  logic        conv_start;
  logic        conv_done;
  logic [7:0]  lm;
  logic [9:0]  rm;
  logic        ro;
  logic        overtemp_out_n;
  logic        overtemp_oe;
  logic        mfp_out_n;
  logic        mfp_oe;
  logic        rd_q;
  logic [15:0] ent;
  logic [15:0] expq[$];
  int          num_errors;
  int          tests_run;
  int          seed;
  int          n;

  tmn_host_model i_host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                         .reg_wr(reg_wr), .reg_rd(reg_rd), .alert_resp_rd(alert_resp_rd));

  tmn_monitor #(.FASTEST_CYC_P(20)) i_dut (
    .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alert_resp_rd(alert_resp_rd),
    .alert_pending(alert_pending), .conv_start(conv_start), .conv_done(conv_done),
    .local_meas(lm), .remote_meas(rm), .remote_open(ro), .overtemp_out_n(overtemp_out_n),
    .overtemp_oe(overtemp_oe), .mfp_out_n(mfp_out_n), .mfp_oe(mfp_oe));

  // clock and start-up values
  initial
  begin
    core_clk  = 1'b0;
    nrst      = 1'b0;
    conv_done = 1'b0;
    lm        = 8'h19;    // in-limit readings, so free-running conversions latch no flag
    rm        = 10'h064;
    ro        = 1'b0;
    seed      = 32'h66c862ad;
  end
  always #10 core_clk = ~core_clk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up();
    if (num_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // note the expected value, then read
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    expq.push_back({m, e});
    i_host.rd(a);
  endtask : rc

  // read data watcher takes the oldest note
  always @(posedge core_clk) rd_q <= reg_rd;
  always @(negedge core_clk)
  begin
    if (rd_q === 1'b1)
    begin
      ent = (expq.size() > 0) ? expq.pop_front() : 16'hFFFF;
      chk(reg_rdata & ent[15:8], ent[7:0]);
    end
  end

  // front end answers each start after a few cycles
  always @(negedge core_clk)
  begin
    if (conv_start === 1'b1)
    begin
      repeat (5) @(negedge core_clk);
      conv_done <= 1'b1;
      @(negedge core_clk);
      conv_done <= 1'b0;
    end
  end

  // cycles until the next start request
  task automatic next_start(output int c);
    c = 0;
    do
    begin
      @(negedge core_clk);
      c++;
    end while (conv_start !== 1'b1 && c < 2000);
  endtask : next_start

  task automatic gap(input logic [7:0] code, input int e);
    i_host.wr(A_RATE_WR, code);
    next_start(n);
    next_start(n);
    chk(n, e);
  endtask : gap

  // one-shot conversion, busy seen while it runs
  task automatic conv(input logic [7:0] l, input logic [9:0] r, input logic o);
    lm = l;
    rm = r;
    ro = o;
    i_host.wr(A_ONESHOT, $random(seed));
    rc(A_STATUS, 8'h80, 8'h80);
    repeat (14) @(negedge core_clk);
  endtask : conv

  // watchdog
  initial
  begin
    #(20 * 20000);
    num_errors++;
    wrap_up();
  end

  // main sequence
  initial
  begin
    num_errors = 0;
    tests_run  = 0;
    repeat (8) @(negedge core_clk);
    nrst = 1'b1;
    rc(A_RATE_RD, 8'h08, 8'hFF);
    rc(A_HYST, 8'h0A, 8'hFF);
    rc(A_OFS_HI, 8'h00, 8'hFF);
    rc(A_OFS_LO, 8'h00, 8'hFF);
    i_host.wr(8'h30, $random(seed));
    rc(8'h30, 8'h00, 8'hFF);
    next_start(n);
    next_start(n);
    chk(n, 80);
    gap(8'h0A, 20);
    gap(8'h09, 40);
    gap(8'h0B, 20);
    gap(8'h07, 160);
    i_host.wr(A_CFG_WR, 8'h40);
    repeat (20) @(negedge core_clk);
    next_start(n);
    chk(n, 2000);
    conv(85, 80, 0);
    rc(A_STATUS, 8'h00, 8'h7F);
    rc(A_LOCAL_VAL, 8'h55, 8'hFF);
    rc(A_REMOTE_HI, 8'h14, 8'hFF);
    chk(alert_pending, 0);
    conv(86, 80, 0);
    rc(A_STATUS, 8'h41, 8'h7F);
    chk({alert_pending, mfp_oe, overtemp_oe}, 3'b111);
    chk({overtemp_out_n, mfp_out_n}, 2'b00);
    conv(80, 80, 0);
    chk(overtemp_oe, 1);
    rc(A_STATUS, 8'h40, 8'h7E);
    rc(A_STATUS, 8'h00, 8'h7E);
    chk(alert_pending, 1);
    i_host.ack();
    @(negedge core_clk);
    chk({alert_pending, mfp_oe}, 2'b00);
    conv(75, 80, 0);
    chk(overtemp_oe, 0);
    rc(A_STATUS, 8'h00, 8'h7F);
    conv(0, 80, 1);
    rc(A_STATUS, 8'h24, 8'h7F);
    i_host.ack();
    @(negedge core_clk);
    chk(alert_pending, 1);
    i_host.wr(A_CFG_WR, 8'hC0);
    repeat (4) @(negedge core_clk);
    chk(mfp_oe, 0);
    conv(50, 80, 0);
    rc(A_STATUS, 8'h24, 8'h7F);
    rc(A_STATUS, 8'h00, 8'h7F);
    i_host.ack();
    @(negedge core_clk);
    chk(alert_pending, 0);
    i_host.wr(A_CFG_WR, 8'hE0);
    conv(50, 344, 0);
    rc(A_STATUS, 8'h12, 8'h7F);
    chk({mfp_oe, overtemp_oe}, 2'b11);
    conv(50, 80, 0);
    rc(A_STATUS, 8'h00, 8'h7F);
    chk({mfp_oe, overtemp_oe}, 2'b00);
    i_host.wr(A_OFS_HI, 8'hFC);
    i_host.wr(A_OFS_LO, 8'h40);
    rc(A_OFS_HI, 8'hFC, 8'hFF);
    rc(A_OFS_LO, 8'h40, 8'hC0);
    conv(50, 344, 0);
    rc(A_REMOTE_HI, 8'h52, 8'hFF);
    rc(A_REMOTE_LO, 8'h40, 8'hC0);
    i_host.wr(A_OFS_HI, 8'h00);
    i_host.wr(A_OFS_LO, 8'h00);
    i_host.wr(A_CFG_WR, 8'h44);
    conv(50, 80, 0);
    rc(A_LOCAL_VAL, 8'h72, 8'hFF);
    rc(A_REMOTE_HI, 8'h54, 8'hFF);
    rc(A_STATUS, 8'h40, 8'h40);
    repeat (4) @(negedge core_clk);
    wrap_up();
  end
endmodule : tmn_monitor_tb_top
